// file: rtl/srfc_pkg.sv
package srfc_pkg;

  // Power selection of the stand-by RAM array
  typedef enum logic [0:0] {
    SRFC_PWR_MAIN    = 1'b0,
    SRFC_PWR_STANDBY = 1'b1
  } srfc_pwr_e;

  // Supply sequencer states
  typedef enum logic [1:0] {
    SRFC_ST_RESET   = 2'b00,
    SRFC_ST_RUN     = 2'b01,
    SRFC_ST_STANDBY = 2'b10
  } srfc_state_e;

  // Supply monitor levels, already compared in the analog domain
  typedef struct packed {
    logic core_above_ref;   // core_supply above standby_core_reference
    logic core_deep_low;    // core_supply below reference by the drop margin
    logic lvd_ok;           // low_voltage_detector: core_supply above 1.0 V
  } srfc_supply_s;

  // Core RAM strobes, active low
  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic cs_n;
  } srfc_strobe_s;

  localparam logic       SRFC_ENABLE_RST   = 1'b0;
  localparam logic       SRFC_FREEZE_RST   = 1'b1;
  localparam srfc_strobe_s SRFC_STROBE_IDLE = 3'h7;
  localparam int unsigned SRFC_CLK_HZ      = 50_000_000;
  localparam int unsigned SRFC_RTC_HZ      = 32_768;
  localparam int unsigned SRFC_RTC_DIV     = SRFC_CLK_HZ / SRFC_RTC_HZ;
  localparam logic [10:0] SRFC_RTC_DIV_MAX = 11'(SRFC_RTC_DIV - 1);
  localparam int unsigned SRFC_RTC_W       = 32;

endpackage

// file: rtl/srfc_rtc_counter.sv
module srfc_rtc_counter (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic                          lp_osc_sel,
  input  wire logic                          main_supply_ok,
  output logic [srfc_pkg::SRFC_RTC_W-1:0]    count
);
  import srfc_pkg::*;

  logic [10:0] div_reg;
  logic        tick;
  logic        run;

  // Main oscillator dies with the main supply; low-power one keeps going
  assign run  = lp_osc_sel || main_supply_ok;
  assign tick = (div_reg == SRFC_RTC_DIV_MAX);

  // Divider gives a one-cycle tick at the reference rate
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_reg <= 11'h000;
    end else if (!run || tick) begin
      div_reg <= 11'h000;
    end else begin
      div_reg <= div_reg + 11'h001;
    end
  end

  // Only the logic's own power-up clears it; internal reset leaves it, and it counts only while lp_osc_sel or main_supply_ok is high
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count <= '0;
    end else if (run && tick) begin
      count <= count + SRFC_RTC_W'(1);
    end
  end

endmodule

// file: rtl/srfc_top.sv
// Notes on behaviour
// - While reset is held, the RAM is disabled and its interface frozen.
// - Clearing the enable bit freezes the RAM interface at once.
// - A reset event moves the RAM power selection to the stand-by supply.
// - Once frozen with the enable bit cleared, the RAM stays frozen until software sets the enable bit after power-on reset.
// - Once the core supply drops below the reference by the drop margin, the RAM stays frozen whatever the enable bit until the supply is back above the reference.
// - With the enable bit set, a brief shallow drop of the core supply does not trigger stand-by switching.
// - Core RAM strobes are blocked during the power-off transient.
// - When internal reset releases, the still frozen RAM goes back to the main supply.
// - The low-voltage detector keeps the device in reset until the core supply exceeds about 1.0 V.
// - The real-time counter keeps counting in stand-by only with the low-power oscillator as reference.
module srfc_top (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic                          external_reset_in_n,
  input  wire srfc_pkg::srfc_supply_s        supply,
  input  wire logic                          enable_wr,
  input  wire logic                          enable_wdata,
  input  wire logic                          lp_osc_sel,
  input  wire srfc_pkg::srfc_strobe_s        core_strobe,
  output logic                               standby_ram_enable,
  output logic                               ram_freeze,
  output srfc_pkg::srfc_pwr_e                ram_pwr_sel,
  output srfc_pkg::srfc_strobe_s             ram_strobe,
  output logic                               int_reset,
  output logic [srfc_pkg::SRFC_RTC_W-1:0]    rtc_count
);
  import srfc_pkg::*;

  logic        reset_reg;
  logic        switch_reg;
  logic        enable_next;
  logic        freeze_next;
  srfc_state_e state_reg;
  srfc_state_e state_next;

  // Internal reset: pin or detector; detector alone is no guarantee
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reset_reg <= 1'b1;
    end else begin
      reset_reg <= !external_reset_in_n || !supply.lvd_ok;
    end
  end
  assign int_reset = reset_reg;

  // Stand-by switch engages on power-on reset and on a deep drop, so shallow dips pass
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      switch_reg <= 1'b1;
    end else if (supply.core_deep_low) begin
      switch_reg <= 1'b1;
    end else if (supply.core_above_ref) begin
      switch_reg <= 1'b0;
    end
  end

  // Enable bit: cleared by reset, set only by software
  always_comb begin
    enable_next = standby_ram_enable;
    if (reset_reg) begin
      enable_next = 1'b0;
    end else if (enable_wr) begin
      enable_next = enable_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      standby_ram_enable <= SRFC_ENABLE_RST;
    end else begin
      standby_ram_enable <= enable_next;
    end
  end

  // Registered so no decode glitch reaches the array
  // Strobe gating uses the next value, so the register costs no extra exposure cycle
  assign freeze_next = reset_reg || !enable_next || switch_reg;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ram_freeze <= SRFC_FREEZE_RST;
    end else begin
      ram_freeze <= freeze_next;
    end
  end

  // Strobes forced idle while frozen: a decaying write strobe never lands
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ram_strobe <= SRFC_STROBE_IDLE;
    end else if (freeze_next) begin
      ram_strobe <= SRFC_STROBE_IDLE;
    end else begin
      ram_strobe <= core_strobe;
    end
  end

  // Power selection sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SRFC_ST_RESET: begin
        if (!reset_reg) state_next = SRFC_ST_RUN;
      end
      SRFC_ST_RUN: begin
        if (reset_reg || switch_reg) state_next = SRFC_ST_STANDBY;
      end
      SRFC_ST_STANDBY: begin
        if (!reset_reg && !switch_reg) state_next = SRFC_ST_RUN;
      end
      default: state_next = SRFC_ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg   <= SRFC_ST_RESET;
      ram_pwr_sel <= SRFC_PWR_STANDBY;
    end else begin
      state_reg   <= state_next;
      ram_pwr_sel <= (state_next == SRFC_ST_RUN) ? SRFC_PWR_MAIN : SRFC_PWR_STANDBY;
    end
  end

  srfc_rtc_counter u_rtc (
    .clk_sys        (clk_sys),
    .nrst           (nrst),
    .lp_osc_sel     (lp_osc_sel),
    .main_supply_ok (supply.lvd_ok),
    .count          (rtc_count)
  );

  // Assertions
  property p_reset_freeze;
    @(posedge clk_sys) disable iff (!nrst) reset_reg |=> ram_freeze && !standby_ram_enable;
  endproperty
  a_reset_freeze: assert property (p_reset_freeze) else $error("RAM not frozen in reset");

  property p_clear_freeze;
    @(posedge clk_sys) disable iff (!nrst) (enable_wr && !enable_wdata) |=> ram_freeze;
  endproperty
  a_clear_freeze: assert property (p_clear_freeze) else $error("Clear did not freeze");

  property p_reset_pwr;
    @(posedge clk_sys) disable iff (!nrst) (state_reg == SRFC_ST_RUN && reset_reg) |=> ram_pwr_sel == SRFC_PWR_STANDBY;
  endproperty
  a_reset_pwr: assert property (p_reset_pwr) else $error("Reset kept main supply");

  property p_stay_frozen;
    @(posedge clk_sys) disable iff (!nrst) (ram_freeze && !standby_ram_enable && !enable_wr) |=> ram_freeze;
  endproperty
  a_stay_frozen: assert property (p_stay_frozen) else $error("Unfroze without enable write");

  property p_switch_freeze;
    @(posedge clk_sys) disable iff (!nrst) supply.core_deep_low |=> ##1 ram_freeze;
  endproperty
  a_switch_freeze: assert property (p_switch_freeze) else $error("Low supply did not freeze");

  property p_shallow_dip;
    @(posedge clk_sys) disable iff (!nrst)
      (standby_ram_enable && !ram_freeze && !switch_reg && !reset_reg && !enable_wr &&
       !supply.core_above_ref && !supply.core_deep_low) |=> !ram_freeze && !switch_reg;
  endproperty
  a_shallow_dip: assert property (p_shallow_dip) else $error("Shallow dip switched");

  property p_strobe_block;
    @(posedge clk_sys) disable iff (!nrst) ram_freeze |-> ram_strobe == SRFC_STROBE_IDLE;
  endproperty
  a_strobe_block: assert property (p_strobe_block) else $error("Strobe reached frozen RAM");

  property p_lvd_reset;
    @(posedge clk_sys) disable iff (!nrst) !supply.lvd_ok |=> int_reset;
  endproperty
  a_lvd_reset: assert property (p_lvd_reset) else $error("Detector did not hold reset");

  property p_exit_main;
    @(posedge clk_sys) disable iff (!nrst)
      (state_reg == SRFC_ST_RESET && !reset_reg) |=> ram_pwr_sel == SRFC_PWR_MAIN && ram_freeze;
  endproperty
  a_exit_main: assert property (p_exit_main) else $error("No return to main supply");

  // Power selection follows the sequencer state in both directions
  property p_standby_exit;
    @(posedge clk_sys) disable iff (!nrst)
      (state_reg == SRFC_ST_STANDBY && !reset_reg && !switch_reg) |=> ram_pwr_sel == SRFC_PWR_MAIN;
  endproperty
  a_standby_exit: assert property (p_standby_exit) else $error("Stand-by exit kept off main");

  property p_run_main;
    @(posedge clk_sys) disable iff (!nrst) state_reg == SRFC_ST_RUN |-> ram_pwr_sel == SRFC_PWR_MAIN;
  endproperty
  a_run_main: assert property (p_run_main) else $error("Running off main supply");

  property p_pwr_hold;
    @(posedge clk_sys) disable iff (!nrst)
      (state_reg == SRFC_ST_STANDBY && reset_reg) |=> ram_pwr_sel == SRFC_PWR_STANDBY;
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("Left stand-by supply in reset");

  // Unfreeze needs every freeze source gone; once unfrozen the core strobes pass unchanged
  property p_unfreeze;
    @(posedge clk_sys) disable iff (!nrst)
      (enable_wr && enable_wdata && !reset_reg && !switch_reg) |=> standby_ram_enable && !ram_freeze;
  endproperty
  a_unfreeze: assert property (p_unfreeze) else $error("Enable write did not unfreeze");

  property p_strobe_pass;
    @(posedge clk_sys) disable iff (!nrst) !ram_freeze |-> ram_strobe == $past(core_strobe);
  endproperty
  a_strobe_pass: assert property (p_strobe_pass) else $error("Strobe lost while unfrozen");

  // Counter must stand still when its only reference has lost its supply
  property p_rtc_stop;
    @(posedge clk_sys) disable iff (!nrst) (!lp_osc_sel && !supply.lvd_ok) |=> $stable(rtc_count);
  endproperty
  a_rtc_stop: assert property (p_rtc_stop) else $error("Counter ran without reference");

  // Main scenarios worth seeing
  c_unfreeze: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(ram_freeze));
  c_standby:  cover property (@(posedge clk_sys) disable iff (!nrst) state_reg == SRFC_ST_STANDBY);
  c_write:    cover property (@(posedge clk_sys) disable iff (!nrst) !ram_strobe.wr_n);
  c_shallow:  cover property (@(posedge clk_sys) disable iff (!nrst)
                              standby_ram_enable && !ram_freeze && !supply.core_above_ref);
  c_pwr_back: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(ram_pwr_sel));

endmodule

// file: verif/srfc_reset_supervisor.sv
module srfc_reset_supervisor (
  input  wire logic                   clk_sys,
  output logic                        rst_pin_n,
  output srfc_pkg::srfc_supply_s      supply
);
  timeunit 1ns;
  timeprecision 1ps;
  import srfc_pkg::*;

  // Supply dead and pin low when the board powers on
  initial begin
    rst_pin_n = 1'b0;
    supply    = 3'h2; // Deep low, detector not ok
  end

  // Ramp the supply with the pin low; release only once stable
  task automatic power_up();
    @(posedge clk_sys);
    supply <= 3'h3; // Detector ok, still under the reference
    repeat (2) @(posedge clk_sys);
    supply <= 3'h5;
    repeat (4) @(posedge clk_sys);
    rst_pin_n <= 1'b1;
  endtask

  // Pin goes low before the supply decays, so no glitch can leave reset
  task automatic power_off();
    @(posedge clk_sys);
    rst_pin_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    supply <= 3'h2;
  endtask

  // Core level moves while the detector stays ok
  task automatic set_level(logic above, logic deep);
    @(posedge clk_sys);
    supply <= {above, deep, 1'b1};
  endtask

  // Faulty pin release on a dead supply, only when a test asks for it
  task automatic glitch_pin();
    @(posedge clk_sys);
    rst_pin_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst_pin_n <= 1'b0;
  endtask
endmodule

// file: verif/test_srfc_top.sv
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module test_srfc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import srfc_pkg::*;

  logic                  clk_sys, nrst, enable_wr, enable_wdata, lp_osc_sel, rst_pin_n;
  logic                  standby_ram_enable, ram_freeze, int_reset;
  srfc_supply_s          supply;
  srfc_strobe_s          core_strobe, ram_strobe;
  srfc_pwr_e             ram_pwr_sel;
  logic [SRFC_RTC_W-1:0] rtc_count, snap;
  int                    bad_count, cmp_count;

  srfc_reset_supervisor i_srfc_reset_supervisor (.clk_sys(clk_sys), .rst_pin_n(rst_pin_n), .supply(supply));
  srfc_top i_srfc_top (.clk_sys(clk_sys), .nrst(nrst), .external_reset_in_n(rst_pin_n), .supply(supply),
    .enable_wr(enable_wr), .enable_wdata(enable_wdata), .lp_osc_sel(lp_osc_sel), .core_strobe(core_strobe),
    .standby_ram_enable(standby_ram_enable), .ram_freeze(ram_freeze), .ram_pwr_sel(ram_pwr_sel),
    .ram_strobe(ram_strobe), .int_reset(int_reset), .rtc_count(rtc_count));

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Wait edges, then step past them so outputs have settled
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One-cycle software write of the enable bit
  task automatic wr_en(logic v);
    @(posedge clk_sys);
    enable_wr    <= 1'b1;
    enable_wdata <= v;
    @(posedge clk_sys);
    enable_wr <= 1'b0;
    #1;
  endtask

  // Single place where the run ends
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Held in reset: frozen, on the stand-by supply, writes refused
  task automatic t_reset_hold();
    cyc(2);
    `CHK("freeze", 1'b1, ram_freeze)
    `CHK("int_reset", 1'b1, int_reset)
    `CHK("enable", 1'b0, standby_ram_enable)
    `CHK("pwr_sel", SRFC_PWR_STANDBY, ram_pwr_sel)
    `CHK("strobe", SRFC_STROBE_IDLE, ram_strobe)
    wr_en(1'b1);
    cyc(1);
    `CHK("enable", 1'b0, standby_ram_enable)
    `CHK("freeze", 1'b1, ram_freeze)
    i_srfc_reset_supervisor.glitch_pin();
    cyc(0);
    `CHK("lvd_hold", 1'b1, int_reset)
  endtask

  // Power up: back to main supply, still frozen until software enables
  task automatic t_power_up();
    i_srfc_reset_supervisor.power_up();
    cyc(4);
    `CHK("int_reset", 1'b0, int_reset)
    `CHK("pwr_sel", SRFC_PWR_MAIN, ram_pwr_sel)
    `CHK("freeze", 1'b1, ram_freeze)
    wr_en(1'b1);
    `CHK("enable", 1'b1, standby_ram_enable)
    `CHK("freeze", 1'b0, ram_freeze)
    cyc(2);
    `CHK("strobe", 3'h2, ram_strobe)
    // A read cycle must pass as well, not only the standing write pattern
    @(posedge clk_sys);
    core_strobe <= 3'h4;
    cyc(2);
    `CHK("strobe_rd", 3'h4, ram_strobe)
    @(posedge clk_sys);
    core_strobe <= 3'h2;
    cyc(1);
  endtask

  // Clearing the bit freezes at once; re-enable right after
  task automatic t_disable();
    wr_en(1'b0);
    `CHK("freeze", 1'b1, ram_freeze)
    cyc(1);
    `CHK("strobe", SRFC_STROBE_IDLE, ram_strobe)
    wr_en(1'b1);
    `CHK("freeze", 1'b0, ram_freeze)
    cyc(2);
  endtask

  // Shallow dip is ignored; deep dip freezes regardless of the bit
  task automatic t_drops();
    i_srfc_reset_supervisor.set_level(1'b0, 1'b0);
    cyc(4);
    `CHK("freeze", 1'b0, ram_freeze)
    `CHK("strobe", 3'h2, ram_strobe)
    i_srfc_reset_supervisor.set_level(1'b0, 1'b1);
    cyc(2);
    `CHK("freeze", 1'b1, ram_freeze)
    wr_en(1'b1);
    `CHK("freeze", 1'b1, ram_freeze)
    i_srfc_reset_supervisor.set_level(1'b1, 1'b0);
    cyc(3);
    `CHK("freeze", 1'b0, ram_freeze)
  endtask

  // Power off with a write strobe low: nothing may reach the array
  task automatic t_power_off();
    i_srfc_reset_supervisor.power_off();
    cyc(2);
    `CHK("freeze", 1'b1, ram_freeze)
    `CHK("enable", 1'b0, standby_ram_enable)
    `CHK("pwr_sel", SRFC_PWR_STANDBY, ram_pwr_sel)
    `CHK("strobe", SRFC_STROBE_IDLE, ram_strobe)
  endtask

  // Counter survives stand-by only on the low-power reference
  task automatic t_rtc();
    snap = rtc_count;
    cyc(1600);
    `CHK("rtc_stop", snap, rtc_count)
    @(posedge clk_sys);
    lp_osc_sel <= 1'b1;
    #1;
    snap = rtc_count;
    cyc(1600);
    `CHK("rtc_run", snap + SRFC_RTC_W'(1600 / SRFC_RTC_DIV), rtc_count)
  endtask

  // Main sequence
  initial begin
    nrst         = 1'b0;
    enable_wr    = 1'b0;
    enable_wdata = 1'b0;
    lp_osc_sel   = 1'b0;
    core_strobe  = 3'h2; // Write and select active
    bad_count    = 0;
    cmp_count    = 0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset_hold();
    t_power_up();
    t_disable();
    t_drops();
    t_power_off();
    t_rtc();
    i_srfc_reset_supervisor.power_up();
    cyc(6);
    `CHK("refrozen", 1'b1, ram_freeze)
    `CHK("enable_off", 1'b0, standby_ram_enable)
    `CHK("pwr_back", SRFC_PWR_MAIN, ram_pwr_sel)
    conclude();
  end

  // Watchdog well beyond the expected run of about 3300 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end
endmodule
